//--- tcp_byte_ser.sv
// Byte serialiser: shifts selected lanes of one dword out to the MAC layer
`timescale 1ns/10ps
module tcp_byte_ser (
    input  wire logic        i_clk,    // System clock
    input  wire logic        i_resetn, // Async reset, active low
    input  wire logic        i_load,   // Take a new dword
    input  wire logic [31:0] i_word,   // Dword holding payload
    input  wire logic [1:0]  i_lane,   // First valid byte lane
    input  wire logic [2:0]  i_nbytes, // Valid bytes, 1 to 4
    input  wire logic        i_eop,    // Dword ends the packet
    input  wire logic        i_ready,  // MAC layer takes a byte
    output logic             o_valid,  // Byte on offer
    output logic [7:0]       o_data,   // Byte value
    output logic             o_last,   // Final byte of packet
    output logic             o_done    // Last byte of dword taken
);
    logic [31:0] sh;
    logic [2:0]  cnt;
    logic        eop;
    logic        take;

    assign take   = o_valid && i_ready;
    assign o_done = take && (cnt == 3'h1);
    assign o_data = sh[7:0];

    // Shift register; lanes below the first are shifted away
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            sh  <= 32'h0;
            cnt <= 3'h0;
            eop <= 1'b0;
        end else if (i_load) begin
            sh  <= i_word >> {i_lane, 3'h0};
            cnt <= i_nbytes;
            eop <= i_eop;
        end else if (take) begin
            sh  <= sh >> 8;
            cnt <= cnt - 3'h1;
        end
    end

    // Valid and last flags; unused tail bytes never leave
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_valid <= 1'b0;
            o_last  <= 1'b0;
        end else if (i_load) begin
            o_valid <= 1'b1;
            o_last  <= i_eop && (i_nbytes == 3'h1);
        end else if (take) begin
            o_valid <= (cnt != 3'h1);
            o_last  <= eop && (cnt == 3'h2);
        end
    end
endmodule : tcp_byte_ser

//--- tcp_dev.sv
// Device end: parses transmit command words and strips offsets and padding
`timescale 1ns/10ps
module tcp_dev (
    input  wire logic  i_clk,          // System clock
    input  wire logic  i_resetn,       // Async reset, active low
    tcp_link_if.dev    link,           // Word link from host
    input  wire logic  i_mac_ready,    // MAC layer takes a byte
    input  wire logic  i_err_clr,      // Clears transmit error flag
    output logic       o_mac_valid,    // Payload byte valid
    output logic [7:0] o_mac_data,     // Payload byte
    output logic       o_mac_last,     // Final byte of packet
    output logic       o_stat_valid,   // Status pulse per packet
    output logic [15:0] o_stat_tag,    // Packet tag
    output logic       o_stat_err,     // Packet had an error
    output logic       o_crc_add,      // Append frame check
    output logic       o_pad_en,       // Pad short frames
    output logic       o_tx_err,       // Transmit error flag, sticky
    output logic       o_buf_loaded    // Buffer loaded flag pulse
);
    typedef enum logic [2:0] {
        TCP_CMDA = 3'b001,
        TCP_CMDB = 3'b010,
        TCP_DATA = 3'b100
    } tcp_state_t;

    // Dwords spanned by a byte count
    function automatic logic [9:0] tcp_words(input logic [11:0] b);
        logic [12:0] s;
        s = {1'b0, b} + 13'h3;
        return s[11:2];
    endfunction : tcp_words

    // Dwords after rounding up to the end alignment
    function automatic logic [9:0] tcp_align(input logic [11:0] b, input logic [1:0] al);
        logic [9:0] w;
        w = tcp_words(b);
        case (al)
            tcp_pkg::AL_16: return (w + 10'h3) & 10'h3FC;
            tcp_pkg::AL_32: return (w + 10'h7) & 10'h3F8;
            default:        return w;
        endcase
    endfunction : tcp_align

    tcp_state_t        state;
    logic [31:0]       cmda;
    logic [31:0]       cmdb_pkt;
    logic [11:0]       cum;
    logic [11:0]       space;
    logic              mism;
    logic [9:0]        wcnt;
    logic [9:0]        tot_w;
    logic [9:0]        last_w;
    logic [10:0]       rem;
    logic              rdy;
    logic              ser_done;

    logic              acc;
    logic [31:0]       w;
    logic [4:0]        off;
    logic [10:0]       size;
    logic              fs;
    logic              ls;
    logic [11:0]       span;
    logic [11:0]       cum_n;
    logic [11:0]       space_n;
    logic              mism_n;
    logic              pkt_err;
    logic              end_b;
    logic              end_d;
    logic              pay;
    logic [1:0]        lane;
    logic [2:0]        room;
    logic [2:0]        nb;
    logic              ld;

    assign link.wready = rdy;
    assign acc  = link.wvalid && rdy;
    assign w    = link.wdata;
    assign off  = cmda[tcp_pkg::CA_OFF_LO +: tcp_pkg::OFF_W];
    assign size = cmda[tcp_pkg::SIZE_W-1:0];
    assign fs   = cmda[tcp_pkg::CA_FS_BIT];
    assign ls   = cmda[tcp_pkg::CA_LS_BIT];
    assign span = {7'h0, off} + {1'b0, size};

    // Per-packet accounting as command B arrives
    always_comb begin
        cum_n   = (fs ? 12'h0 : cum) + {1'b0, size};
        space_n = (fs ? 12'h0 : space)
                + {tcp_words({10'h0, off[1:0]} + {1'b0, size}), 2'h0};
        mism_n  = fs ? 1'b0 : (mism || (w != cmdb_pkt));
        pkt_err = (cum_n[10:0] != w[tcp_pkg::SIZE_W-1:0])
               || cum_n[11] || mism_n
               || (space_n > tcp_pkg::SPACE_MAX);
    end

    // Payload selection for the dword at the current index
    always_comb begin
        pay  = (size != 11'h0) && (wcnt >= {7'h0, off[4:2]})
            && (wcnt <= last_w);
        lane = (wcnt == {7'h0, off[4:2]}) ? off[1:0] : 2'h0;
        room = 3'h4 - {1'b0, lane};
        nb   = (rem < {8'h0, room}) ? rem[2:0] : room;
        ld   = (state == TCP_DATA) && acc && pay;
        end_d = (state == TCP_DATA) && acc && (wcnt + 10'h1 == tot_w);
        end_b = end_d || ((state == TCP_CMDB) && acc
              && (tcp_align(span, cmda[tcp_pkg::CA_ALIGN_LO +: 2]) == 10'h0));
    end

    //----------------------------------------------------------------
    // Word sequencing
    //----------------------------------------------------------------

    // Command A, command B, then data section of the buffer
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state <= TCP_CMDA;
        end else if (acc) begin
            case (state)
                TCP_CMDA: state <= TCP_CMDB;
                TCP_CMDB: state <= end_b ? TCP_CMDA : TCP_DATA;
                TCP_DATA: state <= end_d ? TCP_CMDA : TCP_DATA;
                default:  state <= TCP_CMDA;
            endcase
        end
    end

    // Command capture and packet accounting
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            cmda     <= 32'h0;
            cmdb_pkt <= 32'h0;
            cum      <= 12'h0;
            space    <= 12'h0;
            mism     <= 1'b0;
        end else if (acc && state == TCP_CMDA) begin
            cmda <= w;
        end else if (acc && state == TCP_CMDB) begin
            if (fs) begin
                cmdb_pkt <= w;
            end
            cum   <= cum_n;
            space <= space_n;
            mism  <= mism_n;
        end
    end

    // Data index, total dwords incl. padding, last payload dword
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            wcnt   <= 10'h0;
            tot_w  <= 10'h0;
            last_w <= 10'h0;
            rem    <= 11'h0;
        end else if (acc && state == TCP_CMDB) begin
            wcnt   <= 10'h0;
            tot_w  <= tcp_align(span, cmda[tcp_pkg::CA_ALIGN_LO +: 2]);
            last_w <= tcp_words(span) - 10'h1;
            rem    <= size;
        end else if (acc && state == TCP_DATA) begin
            wcnt <= wcnt + 10'h1;
            if (pay) begin
                rem <= rem - {8'h0, nb};
            end
        end
    end

    // Link ready: held low while a payload dword drains to the MAC layer
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rdy <= 1'b1;
        end else if (ld) begin
            rdy <= 1'b0;
        end else if (ser_done) begin
            rdy <= 1'b1;
        end
    end

    tcp_byte_ser u_ser (
        .i_clk    (i_clk),
        .i_resetn (i_resetn),
        .i_load   (ld),
        .i_word   (w),
        .i_lane   (lane),
        .i_nbytes (nb),
        .i_eop    (ls && (rem == {8'h0, nb})),
        .i_ready  (i_mac_ready),
        .o_valid  (o_mac_valid),
        .o_data   (o_mac_data),
        .o_last   (o_mac_last),
        .o_done   (ser_done)
    );

    //----------------------------------------------------------------
    // Packet status and flags
    //----------------------------------------------------------------

    // Status pulse at the close of the last buffer
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_stat_valid <= 1'b0;
            o_stat_tag   <= 16'h0;
            o_stat_err   <= 1'b0;
            o_crc_add    <= 1'b0;
            o_pad_en     <= 1'b0;
            o_buf_loaded <= 1'b0;
        end else begin
            o_stat_valid <= end_b && ls;
            o_buf_loaded <= end_b && cmda[tcp_pkg::CA_IRQ_BIT];
            if (end_b && ls) begin
                o_stat_tag <= cmdb_pkt[tcp_pkg::CB_TAG_LO +: tcp_pkg::TAG_W];
                o_stat_err <= (cum[10:0] != cmdb_pkt[tcp_pkg::SIZE_W-1:0])
                           || cum[11] || mism || (space > tcp_pkg::SPACE_MAX);
                o_crc_add  <= !cmdb_pkt[tcp_pkg::CB_CRCDIS]
                           || cmdb_pkt[tcp_pkg::CB_PADDIS];
                o_pad_en   <= !cmdb_pkt[tcp_pkg::CB_PADDIS];
            end
        end
    end

    // Sticky error: raised when command B of the last buffer shows a fault; set beats clear
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_tx_err <= 1'b0;
        end else if (acc && state == TCP_CMDB && ls && pkt_err) begin
            o_tx_err <= 1'b1;
        end else if (i_err_clr) begin
            o_tx_err <= 1'b0;
        end
    end
endmodule : tcp_dev

//--- tcp_host.sv
// Host end: APB registers that feed command and data words onto the link
`timescale 1ns/10ps
module tcp_host (
    input  wire logic        i_clk,     // System clock
    input  wire logic        i_resetn,  // Async reset, active low
    input  wire logic        psel,      // APB select
    input  wire logic        penable,   // APB access phase
    input  wire logic        pwrite,    // APB write
    input  wire logic [7:0]  paddr,     // APB byte address
    input  wire logic [31:0] pwdata,    // APB write data
    output logic             pready,    // APB ready
    output logic [31:0]      prdata,    // APB read data
    output logic             pslverr,   // APB error
    tcp_link_if.host         link       // Word link to device
);
    logic        busy;
    logic        expect_b;
    logic        frag;
    logic        seq;
    logic [6:0]  nbuf;
    logic        acc;
    logic        wr_link;
    logic        known;

    assign acc     = psel && penable && !pready;
    assign wr_link = pwrite && (paddr == tcp_pkg::REG_CMDA
                  || paddr == tcp_pkg::REG_CMDB || paddr == tcp_pkg::REG_DATA);
    assign known   = wr_link || (pwrite && paddr == tcp_pkg::REG_CTRL)
                  || (!pwrite && paddr == tcp_pkg::REG_STAT);

    //----------------------------------------------------------------
    // Link word and APB answer
    //----------------------------------------------------------------

    // A link write holds pready low until the device takes the word
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            link.wvalid <= 1'b0;
            link.wdata  <= 32'h0;
            busy        <= 1'b0;
            pready      <= 1'b0;
            pslverr     <= 1'b0;
            prdata      <= 32'h0;
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            if (link.wvalid && link.wready) begin
                link.wvalid <= 1'b0;
                pready      <= 1'b1;
            end else if (acc && wr_link && !busy) begin
                link.wvalid <= 1'b1;
                link.wdata  <= pwdata;
                busy        <= 1'b1;
            end else if (acc && !wr_link) begin
                pready  <= 1'b1;
                pslverr <= !known;
                prdata  <= (!pwrite && paddr == tcp_pkg::REG_STAT)
                         ? {17'h0, nbuf, 6'h0, seq, frag} : 32'h0;
            end
            if (pready) begin
                busy <= 1'b0;
            end
        end
    end

    // Buffer count per packet and order check of command words
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            nbuf     <= 7'h0;
            frag     <= 1'b0;
            seq      <= 1'b0;
            expect_b <= 1'b0;
        end else if (acc && pwrite && paddr == tcp_pkg::REG_CTRL && pwdata[0]) begin
            frag <= 1'b0;
            seq  <= 1'b0;
        end else if (acc && wr_link && !busy) begin
            expect_b <= (paddr == tcp_pkg::REG_CMDA);
            // Each buffer needs command A then command B
            if (expect_b != (paddr == tcp_pkg::REG_CMDB)) begin
                seq <= 1'b1;
            end
            if (paddr == tcp_pkg::REG_CMDA) begin
                nbuf <= pwdata[tcp_pkg::CA_FS_BIT] ? 7'h1 : nbuf + 7'h1;
                // Fragmentation warning past the buffer cap
                if (!pwdata[tcp_pkg::CA_FS_BIT] && nbuf >= tcp_pkg::FRAG_MAX) begin
                    frag <= 1'b1;
                end
                // Middle buffers shorter than four bytes are flagged
                if (!pwdata[tcp_pkg::CA_FS_BIT] && !pwdata[tcp_pkg::CA_LS_BIT]
                    && pwdata[tcp_pkg::SIZE_W-1:0] < 11'h4) begin
                    seq <= 1'b1;
                end
            end
        end
    end
endmodule : tcp_host

//--- tcp_link_if.sv
// Word link from the host end into the device parser
`timescale 1ns/10ps
interface tcp_link_if;
    logic        wvalid;  // Host offers a word
    logic [31:0] wdata;   // Command or data word
    logic        wready;  // Device takes the word

    modport dev  (input wvalid, input wdata, output wready);
    modport host (output wvalid, output wdata, input wready);
endinterface : tcp_link_if

//--- tcp_pkg.sv
// Constants shared by both ends of the transmit command and buffer parser
package tcp_pkg;
    // Command A field positions
    localparam int CA_IRQ_BIT   = 31;
    localparam int CA_ALIGN_LO  = 24;
    localparam int CA_OFF_LO    = 16;
    localparam int CA_FS_BIT    = 13;
    localparam int CA_LS_BIT    = 12;
    // Command B field positions
    localparam int CB_TAG_LO    = 16;
    localparam int CB_CRCDIS    = 13;
    localparam int CB_PADDIS    = 12;
    // Shared field widths
    localparam int SIZE_W       = 11;
    localparam int OFF_W        = 5;
    localparam int TAG_W        = 16;
    // End alignment codes
    localparam logic [1:0] AL_4  = 2'h0;
    localparam logic [1:0] AL_16 = 2'h1;
    localparam logic [1:0] AL_32 = 2'h2;
    // Store-and-forward space limit and buffer cap
    localparam logic [11:0] SPACE_MAX = 12'h7F4;
    localparam logic [6:0]  FRAG_MAX  = 7'h56;
    // Host register byte offsets
    localparam logic [7:0] REG_CMDA  = 8'h00;
    localparam logic [7:0] REG_CMDB  = 8'h04;
    localparam logic [7:0] REG_DATA  = 8'h08;
    localparam logic [7:0] REG_CTRL  = 8'h0C;
    localparam logic [7:0] REG_STAT  = 8'h10;
    // Host status bit positions
    localparam int ST_FRAG_BIT  = 0;
    localparam int ST_SEQ_BIT   = 1;
    localparam int ST_CNT_LO    = 8;
endpackage : tcp_pkg

//--- tcp_properties.sv
// Concurrent checks on the word link, the MAC byte side and the status, loaded and error outputs of the parser
`timescale 1ns/10ps
module tcp_properties (
    input wire logic        i_clk,        // System clock
    input wire logic        i_resetn,     // Async reset, active low
    input wire logic        wvalid,       // Host offers a word
    input wire logic [31:0] wdata,        // Link word
    input wire logic        wready,       // Device takes the word
    input wire logic        i_mac_ready,  // MAC takes a byte
    input wire logic        i_err_clr,    // Error flag clear
    input wire logic        o_mac_valid,  // Byte on offer
    input wire logic [7:0]  o_mac_data,   // Byte value
    input wire logic        o_mac_last,   // Final byte of packet
    input wire logic        o_stat_valid, // Status pulse
    input wire logic        o_tx_err,     // Sticky error flag
    input wire logic        o_buf_loaded  // Loaded pulse
);
    // ------------------------------------------------------------
    // Link, byte stream, status pulse and error flag properties
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);

    // Word accepted on this edge
    logic take;
    assign take = wvalid && wready;

    a_word_held: assert property (wvalid && !wready |=> wvalid && $stable(wdata))
        else $error("link word changed before it was taken");
    a_byte_held: assert property (o_mac_valid && !i_mac_ready |=> o_mac_valid && $stable(o_mac_data))
        else $error("MAC byte changed before it was taken");
    a_last_gap: assert property (o_mac_valid && o_mac_last && i_mac_ready |=> !o_mac_valid)
        else $error("bytes offered past the final byte");
    // Skipped and padding words never stall the link
    a_stall_payload: assert property ($fell(wready) |-> o_mac_valid)
        else $error("link stalled without a payload byte");
    a_ready_back: assert property ($fell(o_mac_valid) |-> ##[0:1] wready)
        else $error("link not reopened after a dword drained");
    a_stat_pulse: assert property (o_stat_valid |=> !o_stat_valid)
        else $error("status pulse longer than one cycle");
    a_stat_cause: assert property (o_stat_valid |-> $past(take))
        else $error("status without a final word taken");
    a_load_cause: assert property (o_buf_loaded |-> $past(take) && !$past(o_buf_loaded))
        else $error("loaded pulse without a final word taken");
    a_err_sticky: assert property (o_tx_err && !i_err_clr |=> o_tx_err)
        else $error("error flag dropped without a clear");
    a_err_cause: assert property ($rose(o_tx_err) |-> $past(take))
        else $error("error flag rose without a word taken");

    // Main scenarios reached
    c_err_packet: cover property (o_stat_valid && o_tx_err);
    c_loaded: cover property (o_buf_loaded);
    c_last_byte: cover property (o_mac_valid && o_mac_last && i_mac_ready);
endmodule : tcp_properties

//--- tx_command_buffer_parser_tb.sv
// Self-checking bench: APB host end driving the device end over the link
`timescale 1ns/10ps
module tx_command_buffer_parser_tb;
    logic        i_clk = 1'h0; // System clock
    logic        i_resetn;     // Async reset, active low
    logic        psel, penable, pwrite, i_mac_ready, i_err_clr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, er;
    logic        o_mac_valid, o_mac_last, o_stat_valid, o_stat_err;
    logic        o_crc_add, o_pad_en, o_tx_err, o_buf_loaded;
    logic [7:0]  o_mac_data;
    logic [15:0] o_stat_tag;
    logic [7:0]  exp[$], got[$];
    bit          slow = 1'h0;
    int          n_errors = 0, tests_run = 0, cyc = 0, ns = 0;
    int          n_stat = 0, n_load = 0, last_at = 0, bc = 0;
    int          offs[5] = '{1, 2, 3, 6, 31};

    tcp_link_if link ();
    tcp_host i_tcp_host (.i_clk(i_clk), .i_resetn(i_resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .link(link));
    tcp_dev i_tcp_dev (.i_clk(i_clk), .i_resetn(i_resetn), .link(link), .i_mac_ready(i_mac_ready),
        .i_err_clr(i_err_clr), .o_mac_valid(o_mac_valid), .o_mac_data(o_mac_data),
        .o_mac_last(o_mac_last), .o_stat_valid(o_stat_valid), .o_stat_tag(o_stat_tag),
        .o_stat_err(o_stat_err), .o_crc_add(o_crc_add), .o_pad_en(o_pad_en),
        .o_tx_err(o_tx_err), .o_buf_loaded(o_buf_loaded));
    tcp_properties i_tcp_properties (.i_clk(i_clk), .i_resetn(i_resetn), .wvalid(link.wvalid),
        .wdata(link.wdata), .wready(link.wready), .i_mac_ready(i_mac_ready), .i_err_clr(i_err_clr),
        .o_mac_valid(o_mac_valid), .o_mac_data(o_mac_data), .o_mac_last(o_mac_last),
        .o_stat_valid(o_stat_valid), .o_tx_err(o_tx_err), .o_buf_loaded(o_buf_loaded));

    // ------------------------------------------------------------
    // Clock, MAC pacing, watchdog and capture
    // ------------------------------------------------------------
    always #5 i_clk = ~i_clk;

    // Slow mode stalls the MAC three cycles in four to exercise back-pressure
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        i_mac_ready <= slow ? (cyc % 4 == 0) : 1'h1;
        if (cyc == 80000) begin
            chk(1'h0, "run timed out");
            give_verdict();
        end
    end

    // Record every byte the MAC takes and each pulse
    always @(posedge i_clk) begin
        if (o_mac_valid === 1'h1 && i_mac_ready === 1'h1) begin
            got.push_back(o_mac_data);
            if (o_mac_last === 1'h1) last_at = got.size();
        end
        if (o_stat_valid === 1'h1) n_stat++;
        if (o_buf_loaded === 1'h1) n_load++;
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk(input bit ok, input string msg);
        tests_run++;
        if (!ok) begin
            n_errors++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask : chk

    // One APB transfer; waits for pready however long it takes
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge i_clk);
        penable <= 1'h1;
        do @(posedge i_clk); while (pready !== 1'h1);
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb

    // Command pair then data section; filler bytes are 0xEE so leaks show
    task automatic send_buf(input bit fs, ls, irq, input logic [1:0] al, input logic [4:0] off,
                            input logic [10:0] sz, input logic [15:0] tag, input bit cd, pd,
                            input logic [10:0] len, input bit fwd);
        int ab, nw, p;
        logic [31:0] wd;
        ab = (al == tcp_pkg::AL_32) ? 32 : (al == tcp_pkg::AL_16) ? 16 : 4;
        nw = (int'(off) + int'(sz) + ab - 1) / ab * ab / 4;
        apb(1'h1, tcp_pkg::REG_CMDA, {irq, 5'h00, al, 3'h0, off, 2'h0, fs, ls, 1'h0, sz});
        apb(1'h1, tcp_pkg::REG_CMDB, {tag, 2'h0, cd, pd, 1'h0, len});
        for (int w = 0; w < nw; w++) begin
            for (int j = 0; j < 4; j++) begin
                p = w * 4 + j - int'(off);
                wd[j*8 +: 8] = (p >= 0 && p < int'(sz)) ? 8'(bc + p) : 8'hEE;
                if (fwd && p >= 0 && p < int'(sz)) exp.push_back(wd[j*8 +: 8]);
            end
            apb(1'h1, tcp_pkg::REG_DATA, wd);
        end
        bc = bc + int'(sz);
    endtask : send_buf

    // Waits for the status pulse and a drained MAC side, then compares
    task automatic wait_pkt(input bit cmp);
        int t;
        bit ok;
        t = 0;
        ok = 1'h1;
        while ((n_stat < ns || got.size() < exp.size() || o_mac_valid !== 1'h0) && t < 30000) begin
            @(posedge i_clk);
            t++;
        end
        repeat (2) @(posedge i_clk);
        chk(t < 30000, "packet wait timed out");
        chk(n_stat == ns, "status pulse count");
        foreach (exp[i]) if (i >= got.size() || got[i] !== exp[i]) ok = 1'h0;
        if (cmp) chk(ok && got.size() == exp.size(), "payload bytes");
        if (cmp) chk(last_at == exp.size(), "final byte marker");
        got.delete();
        exp.delete();
        last_at = 0;
    endtask : wait_pkt

    task automatic clr_err();
        @(posedge i_clk);
        i_err_clr <= 1'h1;
        @(posedge i_clk);
        i_err_clr <= 1'h0;
        @(posedge i_clk);
        chk(o_tx_err === 1'h0, "error flag clears");
    endtask : clr_err

    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : give_verdict

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {psel, penable, pwrite, i_err_clr, i_resetn} = 5'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (8) @(posedge i_clk);
        i_resetn <= 1'h1;
        send_buf(1, 1, 1, tcp_pkg::AL_4, 5'h00, 11'h005, 16'h1234, 0, 0, 11'h005, 1);
        ns++;
        wait_pkt(1);
        chk(o_stat_tag === 16'h1234, "status tag");
        chk(o_stat_err === 1'h0 && o_tx_err === 1'h0, "clean packet");
        chk(n_load == 1, "loaded pulse");
        $display("test single buffer done");
        slow <= 1'h1;
        foreach (offs[i]) begin
            send_buf(1, 0, 0, 2'(i % 3), 5'(offs[i]), 11'h007, 16'h2000, 0, 0, 11'h00E, 1);
            send_buf(0, 0, 0, 2'(2 - i % 3), 5'(31 - offs[i]), 11'h004, 16'h2000, 0, 0, 11'h00E, 1);
            send_buf(0, 1, 0, 2'(i % 3), 5'(offs[i]), 11'h003, 16'h2000, 0, 0, 11'h00E, 1);
            ns++;
            wait_pkt(1);
            chk(o_tx_err === 1'h0, "segmented packet clean");
        end
        slow <= 1'h0;
        chk(n_load == 1, "no loaded pulse without request");
        $display("test offsets and alignment done");
        for (int m = 0; m < 4; m++) begin
            send_buf(1, 1, 0, 2'h3, 5'h02, 11'h003, 16'h3000, m[0], m[1], 11'h003, 1);
            ns++;
            wait_pkt(1);
            chk(o_crc_add === (!m[0] || m[1]), "frame check control");
            chk(o_pad_en === !m[1], "pad control");
        end
        $display("test frame controls done");
        send_buf(1, 1, 0, tcp_pkg::AL_4, 5'h00, 11'h006, 16'h4000, 0, 0, 11'h007, 0);
        ns++;
        wait_pkt(0);
        chk(o_tx_err === 1'h1 && o_stat_err === 1'h1, "length mismatch");
        clr_err();
        send_buf(1, 0, 0, tcp_pkg::AL_4, 5'h00, 11'h004, 16'h5000, 0, 0, 11'h008, 0);
        send_buf(0, 1, 0, tcp_pkg::AL_4, 5'h00, 11'h004, 16'h5001, 0, 0, 11'h008, 0);
        ns++;
        wait_pkt(0);
        chk(o_tx_err === 1'h1, "second command mismatch");
        clr_err();
        $display("test error flag done");
        send_buf(1, 1, 0, tcp_pkg::AL_4, 5'h00, 11'h7F4, 16'h6000, 0, 0, 11'h7F4, 1);
        ns++;
        wait_pkt(1);
        chk(o_tx_err === 1'h0, "space at limit");
        send_buf(1, 1, 0, tcp_pkg::AL_4, 5'h00, 11'h7F5, 16'h6001, 0, 0, 11'h7F5, 0);
        ns++;
        wait_pkt(0);
        chk(o_tx_err === 1'h1, "space over limit");
        clr_err();
        $display("test space limit done");
        apb(1'h0, 8'hFC, 32'h0);
        chk(er === 1'h1, "unmapped read refused");
        apb(1'h0, tcp_pkg::REG_CMDA, 32'h0);
        chk(er === 1'h1, "read of write-only refused");
        // 87 buffers, the second one a short middle buffer: both host flags must rise
        for (int k = 0; k < 87; k++) begin
            send_buf(k < 1, k > 85, 0, tcp_pkg::AL_4, 5'h00, 11'(k == 1 ? 2 : 4), 16'h7000, 0, 0,
                     11'h15A, 0);
        end
        ns++;
        wait_pkt(0);
        apb(1'h0, tcp_pkg::REG_STAT, 32'h0);
        chk(rd[tcp_pkg::ST_SEQ_BIT] === 1'h1 && er === 1'h0, "short middle flagged");
        chk(rd[tcp_pkg::ST_FRAG_BIT] === 1'h1 && rd[14:8] === 7'h57, "buffer cap flagged");
        apb(1'h1, tcp_pkg::REG_CTRL, 32'h1);
        apb(1'h0, tcp_pkg::REG_STAT, 32'h0);
        chk(rd[tcp_pkg::ST_SEQ_BIT] === 1'h0 && rd[tcp_pkg::ST_FRAG_BIT] === 1'h0, "status flags cleared");
        clr_err();
        $display("test host registers done");
        give_verdict();
    end
endmodule : tx_command_buffer_parser_tb
